// file: rtl/cpu_bus_engine.sv
// Purpose: nonpipelined local bus engine behind the reset sequencer
// Assumes: core presents one request at a time with req_valid_i
// Notes:   pipelined states are not built; next-address request is only observed
module cpu_bus_engine
  import cpu_bus_pkg::*;
#(
  parameter int unsigned SELFTEST_LEN = SELFTEST_PERIODS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        doubled_req_i,
  input  wire logic        busy_n_i,
  input  wire logic        test_fault_i,
  input  wire logic        bus_width_select_n_i,
  input  wire logic        ready_n_i,
  input  wire logic        next_address_request_n_i,
  input  wire logic        hold_req_i,
  input  wire logic        req_valid_i,
  input  wire bus_req_type req_i,
  input  wire logic [31:0] data_i,
  output logic             req_ready_o,
  output logic             rdata_valid_o,
  output logic [31:0]      rdata_o,
  output logic             doubled_o,
  output logic             seq_done_o,
  output logic [31:0]      accumulator_register_o,
  output logic             address_strobe_n_o,
  output logic [29:0]      addr_o,
  output logic [3:0]       byte_enables_n_o,
  output cyc_def_type      cyc_def_o,
  output logic             cyc_def_oe_o,
  output logic [31:0]      data_o,
  output logic             data_oe_o,
  output logic             bus_release_grant_o,
  output logic             narrow_bus_o
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pins coming from outside the clock domain

  logic busy_n_s;
  logic ready_n_s;
  logic na_n_s;
  logic hold_n_s;
  logic width_n_s;

  pin_sync u_sync_busy  (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
                         .rst_val_i(1'b1), .pin_i(busy_n_i), .level_o(busy_n_s));
  pin_sync u_sync_ready (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
                         .rst_val_i(1'b1), .pin_i(ready_n_i), .level_o(ready_n_s));
  pin_sync u_sync_na    (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
                         .rst_val_i(1'b1), .pin_i(next_address_request_n_i),
                         .level_o(na_n_s));
  pin_sync u_sync_hold  (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
                         .rst_val_i(1'b1), .pin_i(~hold_req_i), .level_o(hold_n_s));
  pin_sync u_sync_width (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
                         .rst_val_i(1'b1), .pin_i(bus_width_select_n_i),
                         .level_o(width_n_s));

  ////////////////////////////////////////////////////////////////////////////
  // reset sequence: phase alignment, self-test and initialization

  logic phase_two;
  logic seq_ready;

  reset_seq #(.SELFTEST_LEN(SELFTEST_LEN)) u_reset_seq (
    .clk_sys_i              (clk_sys_i),
    .sys_rst_i              (sys_rst_i),
    .clk_en_i               (clk_en_i),
    .busy_n_i               (busy_n_s),
    .test_fault_i           (test_fault_i),
    .phase_two_o            (phase_two),
    .ready_o                (seq_ready),
    .accumulator_register_o (accumulator_register_o)
  );

  assign seq_done_o = seq_ready;

  ////////////////////////////////////////////////////////////////////////////
  // clock-doubling flag; only the core speeds up, the bus keeps half rate

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      doubled_o <= 1'b0;
    end else if (clk_en_i) begin
      doubled_o <= doubled_req_i & seq_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle typing

  function automatic cyc_def_type encode_kind(input cyc_kind_type k, input logic lk);
    cyc_def_type d;
    d = '{mem_io_n: 1'b1, data_code_n: 1'b1, write_read_n: 1'b0, lock_n: ~lk};
    case (k)
      CYC_MEM_READ:  d = '{1'b1, 1'b1, 1'b0, ~lk};
      CYC_MEM_WRITE: d = '{1'b1, 1'b1, 1'b1, ~lk};
      CYC_IO_READ:   d = '{1'b0, 1'b1, 1'b0, 1'b1};
      CYC_IO_WRITE:  d = '{1'b0, 1'b1, 1'b1, 1'b1};
      CYC_CODE_READ: d = '{1'b1, 1'b0, 1'b0, 1'b1};
      CYC_INT_ACK:   d = '{1'b0, 1'b0, 1'b0, 1'b0}; // always locked
      CYC_HALT:      d = '{1'b1, 1'b0, 1'b1, 1'b1};
      CYC_SHUTDOWN:  d = '{1'b1, 1'b0, 1'b1, 1'b1};
      default:       d = '{1'b1, 1'b1, 1'b0, 1'b1};
    endcase
    return d;
  endfunction

  function automatic logic is_write(input cyc_kind_type k);
    return (k == CYC_MEM_WRITE) || (k == CYC_IO_WRITE);
  endfunction

  wire logic        special   = (req_i.kind == CYC_HALT) || (req_i.kind == CYC_SHUTDOWN);
  wire logic [29:0] next_addr = special ? HALT_ADDR : req_i.addr;
  wire logic [3:0]  next_be   = (req_i.kind == CYC_HALT)     ? BE_HALT :
                                (req_i.kind == CYC_SHUTDOWN) ? BE_SHUTDOWN :
                                req_i.byte_en_n;
  wire cyc_def_type next_def  = encode_kind(req_i.kind, req_i.locked);

  ////////////////////////////////////////////////////////////////////////////
  // bus state machine; moves only at the end of phase two (bus clock boundary)

  bus_state_type state;
  bus_state_type next_state;
  logic          cur_write;
  logic          na_seen;

  wire logic boundary  = phase_two & seq_ready;
  wire logic acked     = ~ready_n_s;
  wire logic hold_s    = ~hold_n_s;                          // synchroniser idles high

  // next state decode
  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE: begin
        if (hold_s) next_state = BUS_HOLD;
        else if (req_valid_i) next_state = BUS_FIRST;
      end
      BUS_FIRST: next_state = BUS_SECOND;
      BUS_SECOND: begin
        if (!acked) next_state = BUS_SECOND;
        else if (hold_s) next_state = BUS_HOLD;
        else if (req_valid_i) next_state = BUS_FIRST;
        else next_state = BUS_IDLE;
      end
      BUS_HOLD: begin
        if (!hold_s) next_state = req_valid_i ? BUS_FIRST : BUS_IDLE;
      end
      default: next_state = BUS_IDLE;
    endcase
  end

  wire logic launch = boundary & (next_state == BUS_FIRST);

  // state register: reset aborts everything
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= BUS_IDLE;
    end else if (clk_en_i && boundary) begin
      state <= next_state;
    end
  end

  // address and definition latched at launch, held through wait states
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_o           <= '0;
      byte_enables_n_o <= 4'hF;
      cyc_def_o        <= '{1'b1, 1'b1, 1'b1, 1'b1};
      data_o           <= '0;
      cur_write        <= 1'b0;
    end else if (clk_en_i && launch) begin
      addr_o           <= next_addr;
      byte_enables_n_o <= next_be;
      cyc_def_o        <= next_def;
      data_o           <= req_i.wdata;
      cur_write        <= is_write(req_i.kind) | special;
    end
  end

  // strobe is low for one clock (the first phase of the first state) after launch
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      address_strobe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      address_strobe_n_o <= ~launch;
    end
  end

  // read data capture and next-address observation
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_valid_o <= 1'b0;
      rdata_o       <= '0;
      na_seen       <= 1'b0;
    end else if (clk_en_i) begin
      rdata_valid_o <= boundary & (state == BUS_SECOND) & acked & ~cur_write;
      if (boundary && state == BUS_SECOND && acked) begin
        rdata_o <= data_i;
      end
      // pipelining is not built, so a request is only noted for the cycle
      na_seen <= (state == BUS_SECOND) & ~na_n_s & ~acked;
    end
  end

  assign req_ready_o         = launch;
  assign data_oe_o           = cur_write & ((state == BUS_FIRST) | (state == BUS_SECOND));
  assign cyc_def_oe_o        = (state != BUS_HOLD);
  assign bus_release_grant_o = (state == BUS_HOLD);
  assign narrow_bus_o        = ~width_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_reset_idle;
    @(posedge clk_sys_i) sys_rst_i |=> (state == BUS_IDLE) && address_strobe_n_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");

  property p_reset_undouble;
    @(posedge clk_sys_i) sys_rst_i |=> !doubled_o;
  endproperty
  a_reset_undouble: assert property (p_reset_undouble) else $error("doubled after reset");

  property p_no_bus_early;
    @(posedge clk_sys_i) disable iff (sys_rst_i) !seq_ready |-> address_strobe_n_o;
  endproperty
  a_no_bus_early: assert property (p_no_bus_early) else $error("bus before init");

  property p_first_to_second;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && boundary && state == BUS_FIRST) |=> state == BUS_SECOND;
  endproperty
  a_first_to_second: assert property (p_first_to_second) else $error("first not followed");

  property p_wait_holds;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && boundary && state == BUS_SECOND && !acked) |=> state == BUS_SECOND;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("wait state dropped");

  property p_addr_stable;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state == BUS_SECOND && !launch) |=> $stable(addr_o) && $stable(cyc_def_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in wait");

  property p_intack_locked;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && launch && req_i.kind == CYC_INT_ACK) |=> !cyc_def_o.lock_n;
  endproperty
  a_intack_locked: assert property (p_intack_locked) else $error("int ack not locked");

  property p_halt_be;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && launch && req_i.kind == CYC_HALT) |=> byte_enables_n_o == 4'hB && addr_o == '0;
  endproperty
  a_halt_be: assert property (p_halt_be) else $error("halt encoding wrong");

  property p_strobe_one;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && launch) |=> !address_strobe_n_o ##1 address_strobe_n_o;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe not single");

  property p_hold_grant;
    @(posedge clk_sys_i) disable iff (sys_rst_i) bus_release_grant_o |-> !cyc_def_oe_o;
  endproperty
  a_hold_grant: assert property (p_hold_grant) else $error("definition driven in hold");

  c_read:  cover property (@(posedge clk_sys_i) rdata_valid_o);
  c_wait:  cover property (@(posedge clk_sys_i) boundary && state == BUS_SECOND && !acked);
  c_hold:  cover property (@(posedge clk_sys_i) bus_release_grant_o);
  c_idle:  cover property (@(posedge clk_sys_i) seq_ready && state == BUS_IDLE);

endmodule // cpu_bus_engine

// file: rtl/cpu_bus_pkg.sv
// Purpose: shared constants and types for the reset sequencer and local bus engine
// Assumes: one clock, the double-rate input clock, runs the whole block
// Notes:   counts are in double-rate clock periods
package cpu_bus_pkg;

  localparam int unsigned INIT_PERIODS     = 400;          // initialization length
  localparam int unsigned SELFTEST_PERIODS = 1048576 + 60; // self-test length
  localparam int unsigned CNT_W            = 21;
  localparam int unsigned SYNC_SETTLE      = 4;            // clocks until busy sync settles
  localparam logic [29:0] HALT_ADDR        = 30'h00000000;
  localparam logic [3:0]  BE_HALT          = 4'hB;        // pattern 1011
  localparam logic [3:0]  BE_SHUTDOWN      = 4'hE;        // pattern 1110
  localparam logic [31:0] ACC_PASS         = 32'h00000000;

  typedef enum logic [2:0] {
    CYC_MEM_READ   = 3'h0,
    CYC_MEM_WRITE  = 3'h1,
    CYC_IO_READ    = 3'h2,
    CYC_IO_WRITE   = 3'h3,
    CYC_CODE_READ  = 3'h4,
    CYC_INT_ACK    = 3'h5,
    CYC_HALT       = 3'h6,
    CYC_SHUTDOWN   = 3'h7
  } cyc_kind_type;

  // request presented by the core to the bus engine
  typedef struct packed {
    cyc_kind_type kind;
    logic         locked;
    logic [29:0]  addr;
    logic [3:0]   byte_en_n;
    logic [31:0]  wdata;
  } bus_req_type;

  // cycle-definition outputs, active low as on the pins
  typedef struct packed {
    logic mem_io_n;
    logic data_code_n;
    logic write_read_n;
    logic lock_n;
  } cyc_def_type;

  typedef enum logic [1:0] {
    RST_HOLD  = 2'h0,
    RST_TEST  = 2'h1,
    RST_INIT  = 2'h2,
    RST_DONE  = 2'h3
  } rst_state_type;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'h0,
    BUS_FIRST = 2'h1,
    BUS_SECOND = 2'h2,
    BUS_HOLD  = 2'h3
  } bus_state_type;

endpackage

// file: rtl/pin_sync.sv
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: input is asynchronous to clk_sys_i
// Notes:   output changes once the second and third stages agree
module pin_sync (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  input  wire logic rst_val_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1;
  logic s2;
  logic s3;

  // rst_val_i is not used; the async reset always loads the constant 1
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1      <= 1'b1;
      s2      <= 1'b1;
      s3      <= 1'b1;
      level_o <= 1'b1;
    end else if (clk_en_i) begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end

  logic unused_rv;
  assign unused_rv = rst_val_i;
endmodule // pin_sync

// file: rtl/reset_seq.sv
// Purpose: post-reset sequencer: phase alignment, optional self-test, initialization
// Assumes: reset input already handled as async reset of this domain
// Notes:   self-test is modelled as a counted delay with a fault input
module reset_seq
  import cpu_bus_pkg::*;
#(
  parameter int unsigned SELFTEST_LEN = SELFTEST_PERIODS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        busy_n_i,
  input  wire logic        test_fault_i,
  output logic             phase_two_o,
  output logic             ready_o,
  output logic [31:0]      accumulator_register_o
);
  rst_state_type      state;
  logic [CNT_W-1:0]   cnt;
  logic               first_edge;

  // phase counter: second edge after reset release is phase two
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first_edge  <= 1'b1;
      phase_two_o <= 1'b0;
    end else if (clk_en_i) begin
      first_edge  <= 1'b0;
      phase_two_o <= first_edge ? 1'b1 : ~phase_two_o;
    end
  end

  // sequence: test only when busy was low at release, init always follows
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state                  <= RST_HOLD;
      cnt                    <= '0;
      accumulator_register_o <= ACC_PASS;
    end else if (clk_en_i) begin
      case (state)
        // wait for the synchronised busy level to show the pin before deciding
        RST_HOLD: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(SYNC_SETTLE)) begin
            cnt   <= '0;
            state <= busy_n_i ? RST_INIT : RST_TEST;
          end
        end
        RST_TEST: begin
          if (test_fault_i) begin
            accumulator_register_o <= 32'h00000001;
          end
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(SELFTEST_LEN - 1)) begin
            cnt   <= '0;
            state <= RST_INIT;
          end
        end
        RST_INIT: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(INIT_PERIODS - 1)) begin
            state <= RST_DONE;
          end
        end
        RST_DONE: state <= RST_DONE;
        default:  state <= RST_HOLD;
      endcase
    end
  end

  assign ready_o = (state == RST_DONE);
endmodule // reset_seq

// file: sim/cpu_bus_engine_test.sv
// Purpose: self-checking bench for the reset sequencer and nonpipelined bus engine
// Assumes: ready_responder stands in for the system logic
// Notes:   self-test shortened to ST_LEN clocks
module cpu_bus_engine_test
  import cpu_bus_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned ST_LEN = 20;
  // {mem_io_n, data_code_n, write_read_n, lock_n} per cycle kind
  localparam logic [3:0] DEF_TBL [8] = '{4'hD, 4'hF, 4'h5, 4'h7, 4'h9, 4'h0, 4'hB, 4'hB};
  logic        clk = 1'b0, rst = 1'b1, dbl_req = 1'b0, busy_n = 1'b1, fault = 1'b0;
  logic        wide_n = 1'b1, hold_req = 1'b0, req_valid = 1'b0, ready_n;
  bus_req_type req = '0;
  logic [31:0] din, rdata, acc, wdata, rpat = '0;
  logic [29:0] addr;
  logic [3:0]  be, waits = '0;
  cyc_def_type def;
  logic        req_rdy, rd_valid, dbl, done, strobe_n, def_oe, data_oe, grant, narrow;
  int          error_cnt = 0, checked = 0;
  ////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  // next-address request stays inactive: pipelining is not built
  cpu_bus_engine #(.SELFTEST_LEN(ST_LEN)) dut_u (
    .clk_sys_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1), .doubled_req_i(dbl_req),
    .busy_n_i(busy_n), .test_fault_i(fault), .bus_width_select_n_i(wide_n),
    .ready_n_i(ready_n), .next_address_request_n_i(1'b1), .hold_req_i(hold_req),
    .req_valid_i(req_valid), .req_i(req), .data_i(din), .req_ready_o(req_rdy),
    .rdata_valid_o(rd_valid), .rdata_o(rdata), .doubled_o(dbl), .seq_done_o(done),
    .accumulator_register_o(acc), .address_strobe_n_o(strobe_n), .addr_o(addr),
    .byte_enables_n_o(be), .cyc_def_o(def), .cyc_def_oe_o(def_oe), .data_o(wdata),
    .data_oe_o(data_oe), .bus_release_grant_o(grant), .narrow_bus_o(narrow));
  ready_responder sys_u (.clk_sys_i(clk), .address_strobe_n_i(strobe_n),
    .waits_i(waits), .rdata_i(rpat), .ready_n_o(ready_n), .data_o(din));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("summary: %0d checks, %0d errors", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for a level, one check whatever happens
  task automatic wait_on(ref logic sig, input logic val, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig !== val && n < lim);
    check(32'(sig === val), 32'h1);
  endtask
  // no strobe and no read data for a while
  task automatic quiet(input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(posedge clk);
      bad += int'(strobe_n !== 1'b1 || rd_valid === 1'b1);
    end
    check(32'(bad), 32'h0);
  endtask
  // reset long enough for self-test, busy kept steady around the release
  task automatic do_reset(input logic bn, input logic flt, output int n);
    @(posedge clk);
    rst <= 1'b1;
    busy_n <= bn;
    fault <= flt;
    repeat (90) @(posedge clk);
    check({24'h0, strobe_n, 4'(def), grant, dbl, data_oe}, 32'hF8);
    rst <= 1'b0;
    dbl_req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
      if (n == 80) busy_n <= 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_reset();
    int n;
    do_reset(1'b1, 1'b0, n);
    check(32'(n >= 400 && n <= 412), 32'h1);
    do_reset(1'b0, 1'b1, n);
    check(32'(n >= 400 + ST_LEN && n <= 412 + ST_LEN), 32'h1);
    check(acc, 32'h1);
    do_reset(1'b0, 1'b0, n);
    check(acc, ACC_PASS);
    $display("reset sequence test finished");
  endtask
  // one cycle of kind i % 8, locked from i = 8 on, with i % 4 + 2 wait states
  task automatic run_cycle(input int i);
    logic [3:0]  d;
    logic [29:0] a;
    int          bad;
    d = DEF_TBL[i % 8] & {3'h7, i < 8};
    a = (i % 8 >= 6) ? 30'h0 : 30'h2ABCDEF0 + 30'(i);
    @(posedge clk);
    waits <= 4'(i % 4);
    rpat <= 32'hA5A50000 + 32'(i);
    req_valid <= 1'b1;
    req <= '{cyc_kind_type'(3'(i)), i >= 8, 30'h2ABCDEF0 + 30'(i), 4'h0,
             32'hC0DE0000 + 32'(i)};
    wait_on(req_rdy, 1'b1, 40);
    req_valid <= 1'b0;
    wait_on(strobe_n, 1'b0, 4);
    check({24'h0, be, 4'(def)}, {24'h0, i % 8 == 6 ? BE_HALT :
          i % 8 == 7 ? BE_SHUTDOWN : 4'h0, d});
    check({2'h0, addr}, {2'h0, a});
    // ready cannot have been seen yet, so everything must still stand
    bad = 0;
    repeat (2 * (i % 4) + 3) begin
      @(posedge clk);
      bad += int'(addr !== a || 4'(def) !== d || rd_valid === 1'b1 || strobe_n !== 1'b1);
    end
    check(32'(bad), 32'h0);
    check(data_oe ? wdata : 32'h0, d[1] ? 32'hC0DE0000 + 32'(i) : 32'h0);
    if (d[1] == 1'b0) begin
      wait_on(rd_valid, 1'b1, 12);
      check(rdata, 32'hA5A50000 + 32'(i));
    end
    quiet(12);
  endtask
  task automatic test_cycles();
    for (int i = 0; i < 10; i++)
      run_cycle(i);
    $display("cycle type test finished");
  endtask
  // a request raised during hold must wait until hold is withdrawn
  task automatic test_hold();
    @(posedge clk);
    hold_req <= 1'b1;
    wait_on(grant, 1'b1, 20);
    check({31'h0, def_oe}, 32'h0);
    req_valid <= 1'b1;
    req <= '{CYC_MEM_READ, 1'b0, 30'h1, 4'h0, 32'h0};
    quiet(10);
    req_valid <= 1'b0;
    hold_req <= 1'b0;
    wait_on(grant, 1'b0, 10);
    run_cycle(0);
    $display("hold test finished");
  endtask
  // reset in the middle of a long write while doubled and narrow
  task automatic test_abort();
    int n;
    @(posedge clk);
    dbl_req <= 1'b1;
    wide_n <= 1'b0;
    waits <= 4'hF;
    req_valid <= 1'b1;
    req <= '{CYC_MEM_WRITE, 1'b1, 30'h5, 4'h0, 32'h1234};
    wait_on(req_rdy, 1'b1, 40);
    req_valid <= 1'b0;
    wait_on(dbl, 1'b1, 20);
    wait_on(narrow, 1'b1, 8);
    check({30'h0, narrow, data_oe}, 32'h3);
    wide_n <= 1'b1;
    do_reset(1'b1, 1'b0, n);
    run_cycle(2);
    $display("abort test finished");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    test_reset();
    test_cycles();
    test_hold();
    test_abort();
    stop_test();
  end
  // watchdog: the whole run needs well under 6000 clocks
  initial begin
    #(100 * 20000);
    error_cnt++;
    stop_test();
  end
endmodule // cpu_bus_engine_test

// file: sim/ready_responder.sv
// Purpose: system logic model that answers each bus cycle with ready
// Assumes: a one-clock low strobe opens a cycle; waits_i is steady per cycle
// Notes:   ready is driven high again once its pulse has run out
module ready_responder
  import cpu_bus_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        address_strobe_n_i,
  input  wire logic [3:0]  waits_i,
  input  wire logic [31:0] rdata_i,
  output logic             ready_n_o,
  output logic [31:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 40;
  int rdy_at;
  ////////////////////////////////////////////////////////////
  // ready never lands in the first state, only after the chosen waits
  assign rdy_at = 2 * int'(waits_i) + 1;
  initial begin
    ready_n_o = 1'b1;
    data_o = '0;
  end
  // clocks since the last strobe; parks at 40 between cycles
  always @(posedge clk_sys_i) begin
    cnt <= !address_strobe_n_i ? 0 : (cnt < 40 ? cnt + 1 : 40);
  end
  // short ready pulse; read data turns over once its hold has run out,
  // so a late capture cannot pass by luck
  always @(posedge clk_sys_i) begin
    ready_n_o <= !(cnt >= rdy_at && cnt < rdy_at + 4);
    data_o    <= (cnt <= rdy_at + 6) ? rdata_i : ~rdata_i;
  end
endmodule // ready_responder
